// >>> prhc_pkg.sv
/*
 Constants shared by the reference and holdover control block: register
 offsets, field positions, reset values and holdover controller states.
 Assumes an 8-bit register port with byte-wide data.
*/
package prhc_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_THR_SEL = 8'h1a;   // Threshold select
   localparam logic [7:0] ADDR_REF_CTRL = 8'h1c;  // reference_input_control
   localparam logic [7:0] ADDR_HO_CTRL = 8'h1d;   // holdover_control
   localparam logic [7:0] ADDR_STATUS = 8'h1f;    // pll_status_readback
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;  // Sticky events, W1C
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;  // Event mask
   // ==========================================================
   // Field positions
   localparam int THR_SEL_BIT = 6;      // SECOND_REFERENCE_INPUT threshold choice
   localparam int SECOND_REFERENCE_INPUT_PWR_BIT = 2;     // Second input power
   localparam int FIRST_REFERENCE_INPUT_PWR_BIT = 1;     // First input power
   localparam int DIFF_REF_BIT = 0;     // Differential mode
   localparam int STAT_DIS_BIT = 4;     // Status readback disable
   localparam int LD_CMP_BIT = 3;       // Lock-detect comparator
   localparam int HO_EN_HI_BIT = 2;     // Holdover enable, upper
   localparam int EXT_HO_BIT = 1;       // External holdover
   localparam int HO_EN_LO_BIT = 0;     // Holdover enable, lower
   localparam int ST_CAL_BIT = 6;       // Calibration finished
   localparam int ST_HOLD_BIT = 5;      // In holdover
   localparam int ST_SECOND_REFERENCE_INPUT_BIT = 4;      // Second input selected
   localparam int ST_VCO_BIT = 3;       // VCO above threshold
   localparam int ST_REF2F_BIT = 2;     // SECOND_REFERENCE_INPUT above threshold
   localparam int ST_REF1F_BIT = 1;     // FIRST_REFERENCE_INPUT above threshold
   localparam int ST_LOCK_BIT = 0;      // Digital lock
   localparam int EV_HOLD_BIT = 0;      // Event: holdover entered
   localparam int EV_UNLOCK_BIT = 1;    // Event: lock lost
   localparam int EV_CAL_BIT = 2;       // Event: calibration done
   localparam int EV_WIDTH = 3;
   // ==========================================================
   // Reset values
   localparam logic [7:0] THR_SEL_RST = 8'h00;
   localparam logic [7:0] REF_CTRL_RST = 8'h00;
   localparam logic [7:0] HO_CTRL_RST = 8'h00;
   localparam logic [2:0] IRQ_RST = 3'h0;
   // ==========================================================
   // Automatic holdover controller states
   typedef enum logic [1:0] {
      PRHC_IDLE,     // Waiting for lock on a good reference
      PRHC_LOCKED,   // Locked, watching the reference
      PRHC_HOLD      // Reference lost after lock, holding
   } prhc_ho_state_t;
endpackage

// >>> prhc_holdover.sv
/*
 Holdover controller: automatic state machine plus external pin control.
 Assumes all inputs are synchronous to i_clk and the enable and mode come
 from the register file of the enclosing block.
*/
`timescale 1ns/1ps
module prhc_holdover (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_enable,       // Both enable bits set
   input wire logic i_external,     // Pin-driven mode
   input wire logic i_sync_n,       // External hold pin, low holds
   input wire logic i_ld_true,      // Lock-detect pin judged true
   input wire logic i_ref_ok,       // Selected reference is good
   input wire logic i_locked,       // Digital lock
   output logic o_holdover          // In holdover state
);
   import prhc_pkg::*;

   prhc_ho_state_t state;           // Automatic controller state
   prhc_ho_state_t next_state;
   logic auto_run;                  // Automatic controller allowed

   assign auto_run = i_enable && !i_external;

   // ==========================================================
   // Next state
   always_comb begin
      next_state = state;
      case (state)
         PRHC_IDLE: begin
            if (i_locked && i_ref_ok) begin
               next_state = PRHC_LOCKED;
            end
         end
         PRHC_LOCKED: begin
            // Hold only if the loop was locked before the loss
            if (!i_ref_ok && i_ld_true) begin
               next_state = PRHC_HOLD;
            end else if (!i_ref_ok) begin
               next_state = PRHC_IDLE;
            end
         end
         PRHC_HOLD: begin
            // Reference back: reacquire from scratch
            if (i_ref_ok) begin
               next_state = PRHC_IDLE;
            end
         end
         default: next_state = PRHC_IDLE;
      endcase
      if (!auto_run) begin
         next_state = PRHC_IDLE;
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= PRHC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Holdover flag, from the machine or from the pin
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_holdover <= 1'b0;
      end else if (!i_enable) begin
         o_holdover <= 1'b0;
      end else if (i_external) begin
         o_holdover <= !i_sync_n;
      end else begin
         o_holdover <= (next_state == PRHC_HOLD);
      end
   end

   a_ext_follows_pin: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_enable && i_external) |=> (o_holdover == !$past(i_sync_n)))
      else $error("External holdover does not follow pin");

   a_auto_needs_ld: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (auto_run && state == PRHC_LOCKED && !i_ref_ok && !i_ld_true)
      |=> !o_holdover)
      else $error("Holdover entered without lock-detect pin");
endmodule

// >>> prhc_top.sv
/*
 Reference input power, reference mode and holdover control with a
 read-only PLL status register, an event interrupt and a byte register
 port. Assumes a master that issues one-cycle read or write strobes and
 takes read data in the cycle after the read strobe.
*/
// Operation
// - Bit 2 powers second reference input
// - Bit 1 powers first reference input
// - Bit 0 selects differential reference mode
// - Bit 4 disables status register readback
// - Bit 3 enables lock-detect pin comparator
// - Comparator off: pin treated as true
// - Holdover needs both bits 2 and 0
// - Bit 1 hands holdover to sync pin
// - Status bit 6: calibration finished
// - Status bit 5: holdover state active
// - Status bit 4: second reference selected
// - Status bit 3: VCO above threshold
// - Status bit 2: second reference above threshold
// - Status bit 1: first reference above threshold
// - Status bit 0: digital lock detect
`timescale 1ns/1ps
module prhc_top (
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Live conditions from the analog and PLL side
   input wire logic i_vco_cal_done,       // Calibration finished
   input wire logic i_vco_above_thr,      // VCO frequency monitor
   input wire logic i_first_reference_input_above_thr,     // First input monitor
   input wire logic i_second_reference_input_above_thr,     // Second input monitor
   input wire logic i_digital_lock,       // Digital lock detect
   input wire logic i_second_reference_input_in_use,        // Switch feeds second input
   input wire logic i_selected_ref_ok,    // Selected reference good
   input wire logic i_lock_detect_pin,    // Comparator on the LD pin
   input wire logic i_sync_n,             // External holdover pin
   // Controls to the analog side
   output logic o_first_reference_input_pwr,
   output logic o_second_reference_input_pwr,
   output logic o_diff_ref_mode,
   output logic o_ld_comparator_en,
   output logic o_second_reference_input_thr_sel,
   output logic o_holdover_active,
   output logic o_irq
);
   import prhc_pkg::*;

   // ==========================================================
   // Register storage
   logic [7:0] thr_sel_reg;      // Threshold select register
   logic [7:0] ref_ctrl;         // reference_input_control
   logic [7:0] ho_ctrl;          // holdover_control
   logic [EV_WIDTH-1:0] irq_stat; // Sticky events
   logic [EV_WIDTH-1:0] irq_mask; // Event enables
   logic [EV_WIDTH-1:0] events;  // One-cycle event pulses
   logic [7:0] status;           // Live status byte
   logic [7:0] next_rdata;       // Read mux result
   logic ho_enable;              // Both holdover bits set
   logic ld_true;                // Lock-detect as seen by holdover
   logic holdover;               // Controller output
   logic hold_q;                 // Previous holdover, for edges
   logic lock_q;                 // Previous lock, for edges
   logic cal_q;                  // Previous calibration flag

   // Write strobe qualified by address
   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = i_wr && (i_addr == a);
   endfunction

   // ==========================================================
   // Reference input control register
   // Writes to the status offset fall through and are dropped.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ref_ctrl <= REF_CTRL_RST;
      end else if (wr_hit(ADDR_REF_CTRL)) begin
         ref_ctrl <= i_wdata;
      end
   end

   // Holdover control register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ho_ctrl <= HO_CTRL_RST;
      end else if (wr_hit(ADDR_HO_CTRL)) begin
         ho_ctrl <= i_wdata;
      end
   end

   // Threshold select register, only bit 6 kept meaningful
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         thr_sel_reg <= THR_SEL_RST;
      end else if (wr_hit(ADDR_THR_SEL)) begin
         thr_sel_reg <= i_wdata;
      end
   end

   // ==========================================================
   // Control outputs, each straight from a flop
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_first_reference_input_pwr <= 1'b0;
         o_second_reference_input_pwr <= 1'b0;
         o_diff_ref_mode <= 1'b0;
         o_ld_comparator_en <= 1'b0;
         o_second_reference_input_thr_sel <= 1'b0;
      end else begin
         o_second_reference_input_pwr <= ref_ctrl[SECOND_REFERENCE_INPUT_PWR_BIT];
         o_first_reference_input_pwr <= ref_ctrl[FIRST_REFERENCE_INPUT_PWR_BIT];
         // Switchover only works single-ended; not enforced here
         o_diff_ref_mode <= ref_ctrl[DIFF_REF_BIT];
         o_ld_comparator_en <= ho_ctrl[LD_CMP_BIT];
         o_second_reference_input_thr_sel <= thr_sel_reg[THR_SEL_BIT];
      end
   end

   // ==========================================================
   // Holdover
   assign ho_enable = ho_ctrl[HO_EN_HI_BIT] && ho_ctrl[HO_EN_LO_BIT];
   // With the comparator off the pin always counts as locked before
   assign ld_true = !ho_ctrl[LD_CMP_BIT] || i_lock_detect_pin;

   // Calibration hazard is left to software: holdover is not gated
   // by calibration, since the hardware cannot know intent.
   prhc_holdover u_holdover (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_enable(ho_enable),
      .i_external(ho_ctrl[EXT_HO_BIT]),
      .i_sync_n(i_sync_n),
      .i_ld_true(ld_true),
      .i_ref_ok(i_selected_ref_ok),
      .i_locked(i_digital_lock),
      .o_holdover(holdover)
   );

   // Pass the controller flop out unchanged
   assign o_holdover_active = holdover;

   // ==========================================================
   // Live status byte; bit 7 reserved reads zero
   always_comb begin
      status = 8'h00;
      status[ST_CAL_BIT] = i_vco_cal_done;
      status[ST_HOLD_BIT] = holdover;
      // Differential mode always counts as the first input
      status[ST_SECOND_REFERENCE_INPUT_BIT] = i_second_reference_input_in_use && !ref_ctrl[DIFF_REF_BIT];
      status[ST_VCO_BIT] = i_vco_above_thr;
      status[ST_REF2F_BIT] = i_second_reference_input_above_thr;
      status[ST_REF1F_BIT] = i_first_reference_input_above_thr;
      status[ST_LOCK_BIT] = i_digital_lock;
   end

   // ==========================================================
   // Read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = 8'h00;
      case (i_addr)
         ADDR_THR_SEL: next_rdata = thr_sel_reg;
         ADDR_REF_CTRL: next_rdata = ref_ctrl;
         ADDR_HO_CTRL: next_rdata = ho_ctrl;
         ADDR_STATUS: begin
            // Disabled readback returns zero, no side effect
            if (!ho_ctrl[STAT_DIS_BIT]) begin
               next_rdata = status;
            end
         end
         ADDR_IRQ_STAT: next_rdata = {5'h00, irq_stat};
         ADDR_IRQ_MASK: next_rdata = {5'h00, irq_mask};
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // ==========================================================
   // Edge history for event detection
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hold_q <= 1'b0;
         lock_q <= 1'b0;
         cal_q <= 1'b0;
      end else begin
         hold_q <= holdover;
         lock_q <= i_digital_lock;
         cal_q <= i_vco_cal_done;
      end
   end

   // Event pulses: holdover entered, lock lost, calibration done
   always_comb begin
      events = '0;
      events[EV_HOLD_BIT] = holdover && !hold_q;
      events[EV_UNLOCK_BIT] = lock_q && !i_digital_lock;
      events[EV_CAL_BIT] = i_vco_cal_done && !cal_q;
   end

   // ==========================================================
   // Sticky status; a set in the clearing cycle wins
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_stat <= IRQ_RST;
      end else if (wr_hit(ADDR_IRQ_STAT)) begin
         irq_stat <= (irq_stat & ~i_wdata[EV_WIDTH-1:0]) | events;
      end else begin
         irq_stat <= irq_stat | events;
      end
   end

   // Mask register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_mask <= IRQ_RST;
      end else if (wr_hit(ADDR_IRQ_MASK)) begin
         irq_mask <= i_wdata[EV_WIDTH-1:0];
      end
   end

   // Level interrupt, one cycle behind the sticky bits
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat & irq_mask);
      end
   end

   // ==========================================================
   // Checks
   a_second_reference_input_power: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      wr_hit(ADDR_REF_CTRL) |=> ##1
      (o_second_reference_input_pwr == $past(i_wdata[SECOND_REFERENCE_INPUT_PWR_BIT], 2)))
      else $error("Second input power does not follow write");

   a_first_reference_input_power: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      wr_hit(ADDR_REF_CTRL) |=> ##1
      (o_first_reference_input_pwr == $past(i_wdata[FIRST_REFERENCE_INPUT_PWR_BIT], 2)))
      else $error("First input power does not follow write");

   a_diff_mode: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      wr_hit(ADDR_REF_CTRL) |=> ##1
      (o_diff_ref_mode == $past(i_wdata[DIFF_REF_BIT], 2)))
      else $error("Reference mode does not follow write");

   a_readback_off: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == ADDR_STATUS && ho_ctrl[STAT_DIS_BIT])
      |=> (o_rdata == 8'h00))
      else $error("Status read while readback disabled");

   a_cmp_enable: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      ##1 (o_ld_comparator_en == $past(ho_ctrl[LD_CMP_BIT])))
      else $error("Comparator enable does not follow register");

   a_hold_needs_en: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      !ho_enable |=> !o_holdover_active)
      else $error("Holdover active while disabled");

   a_status_read: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == ADDR_STATUS && !ho_ctrl[STAT_DIS_BIT])
      |=> (o_rdata[ST_CAL_BIT] == $past(i_vco_cal_done))
      && (o_rdata[ST_LOCK_BIT] == $past(i_digital_lock))
      && (o_rdata[ST_HOLD_BIT] == $past(holdover)))
      else $error("Status bits differ from live conditions");

   a_second_reference_input_sel_diff: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == ADDR_STATUS && ref_ctrl[DIFF_REF_BIT])
      |=> !o_rdata[ST_SECOND_REFERENCE_INPUT_BIT])
      else $error("Second input reported in differential mode");

   a_freq_bits: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == ADDR_STATUS && !ho_ctrl[STAT_DIS_BIT])
      |=> (o_rdata[ST_VCO_BIT] == $past(i_vco_above_thr))
      && (o_rdata[ST_REF2F_BIT] == $past(i_second_reference_input_above_thr))
      && (o_rdata[ST_REF1F_BIT] == $past(i_first_reference_input_above_thr)))
      else $error("Frequency monitor bits differ from inputs");

   a_status_no_write: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      wr_hit(ADDR_STATUS) |=> $stable(ref_ctrl) && $stable(ho_ctrl))
      else $error("Status write altered control registers");

   a_irq_sticky: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (events[EV_HOLD_BIT]) |=> irq_stat[EV_HOLD_BIT])
      else $error("Holdover event lost");

   a_thr_sel_out: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      ##1 (o_second_reference_input_thr_sel == $past(thr_sel_reg[THR_SEL_BIT])))
      else $error("Threshold select does not follow register");

   a_second_reference_input_selected: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == ADDR_STATUS && !ho_ctrl[STAT_DIS_BIT]
      && !ref_ctrl[DIFF_REF_BIT])
      |=> (o_rdata[ST_SECOND_REFERENCE_INPUT_BIT] == $past(i_second_reference_input_in_use)))
      else $error("Second input selection misreported");

   a_rdata_idle: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      !i_rd |=> (o_rdata == 8'h00))
      else $error("Read data present without a read");

   a_irq_level: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      ##1 (o_irq == $past(|(irq_stat & irq_mask))))
      else $error("Interrupt level does not follow status");

   a_w1c_clear: assert property (
      @(posedge i_clk) disable iff (!i_reset_n)
      (wr_hit(ADDR_IRQ_STAT) && i_wdata[EV_HOLD_BIT]
      && !events[EV_HOLD_BIT])
      |=> !irq_stat[EV_HOLD_BIT])
      else $error("Holdover event not cleared by write");
endmodule

// >>> prhc_tb.sv
/*
 Self-checking testbench for the reference and holdover control block.
 Assumes the design files and the prhc_pkg package are compiled first; the
 bench drives every port itself, with no separate partner model.
*/
`timescale 1ns/1ps
module testbench;
   import prhc_pkg::*;
   // ==========================================================
   // Clock, reset and stimulus
   logic i_clk;                 // 125 MHz register clock
   logic i_reset_n;             // Asynchronous reset, active low
   logic [7:0] i_addr;          // Register offset
   logic [7:0] i_wdata;         // Write data
   logic i_wr;                  // Write strobe
   logic i_rd;                  // Read strobe
   logic [7:0] o_rdata;         // Read data, cycle after the strobe
   logic [6:0] live;            // Live conditions, status bit layout
   logic ref_ok;                // Selected reference good
   logic ld_pin;                // Lock-detect comparator result
   logic sync_n;                // External holdover pin, low holds
   logic pwr1, pwr2, diff, ldcmp, thr, hold, irq;
   int failures;                // Mismatches seen
   int tests_run;               // Comparisons made
   int seed;                    // Fixed seed keeps runs repeatable
   logic [7:0] rc, ho, ts, got; // Register shadows rc, ho, ts; got takes read data
   // ==========================================================
   // Device under test
   prhc_top i_dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_vco_cal_done(live[6]), .i_vco_above_thr(live[3]),
      .i_first_reference_input_above_thr(live[1]), .i_second_reference_input_above_thr(live[2]),
      .i_digital_lock(live[0]), .i_second_reference_input_in_use(live[4]),
      .i_selected_ref_ok(ref_ok), .i_lock_detect_pin(ld_pin),
      .i_sync_n(sync_n), .o_first_reference_input_pwr(pwr1),
      .o_second_reference_input_pwr(pwr2), .o_diff_ref_mode(diff),
      .o_ld_comparator_en(ldcmp), .o_second_reference_input_thr_sel(thr),
      .o_holdover_active(hold), .o_irq(irq));
   // Free-running clock, 8 ns period
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // ==========================================================
   // Tasks and expectation functions
   // Compare one byte-sized result and count it
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Let n rising edges pass, then step clear of the edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // One-cycle write strobe, signals changed just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   // One-cycle read strobe; data stand only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask
   // Status byte worked out from the live inputs and control shadows
   function automatic logic [7:0] exp_status(input logic [7:0] h,
      input logic [7:0] r, input logic [6:0] l, input logic hs);
      if (h[STAT_DIS_BIT])
         return 8'h00;
      return {1'b0, l[6], hs, l[4] & ~r[DIFF_REF_BIT], l[3:0]};
   endfunction
   // Control outputs packed in a byte for one comparison
   function automatic logic [7:0] exp_ctrl(input logic [7:0] r,
      input logic [7:0] h, input logic [7:0] t);
      return {3'h0, t[THR_SEL_BIT], h[LD_CMP_BIT], r[2:0]};
   endfunction
   // Print counts and the verdict, then stop
   task automatic close_out();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog: a hang counts as a mismatch
   initial begin
      #400000;
      failures++;
      close_out();
   end
   // ==========================================================
   // Main sequence
   initial begin
      seed = 98;
      i_reset_n = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_wr = 1'b0;
      i_rd = 1'b0;
      live = 7'h00;
      ref_ok = 1'b0;
      ld_pin = 1'b0;
      sync_n = 1'b1;
      repeat (16) @(posedge i_clk);
      i_reset_n <= 1'b1;
      tick(1);
      // Reset values of registers and outputs
      chk("ctrl_rst", 8'h00, {3'h0, thr, ldcmp, pwr2, pwr1, diff});
      rd(ADDR_REF_CTRL, got);
      chk("ref_ctrl_rst", REF_CTRL_RST, got);
      rd(ADDR_HO_CTRL, got);
      chk("ho_ctrl_rst", HO_CTRL_RST, got);
      tick(1);
      chk("rdata_idle", 8'h00, o_rdata);
      rd(8'h33, got);
      chk("unmapped", 8'h00, got);
      // Random control and live conditions, holdover kept disabled
      for (int k = 0; k < 24; k++) begin
         rc = 8'($random(seed));
         ho = 8'($random(seed)) & 8'hfa;
         ts = 8'($random(seed));
         wr(ADDR_REF_CTRL, rc);
         wr(ADDR_HO_CTRL, ho);
         wr(ADDR_THR_SEL, ts);
         wr(ADDR_STATUS, 8'($random(seed))); // A read-only place
         live <= 7'($random(seed));
         tick(2);
         chk("ctrl_out", exp_ctrl(rc, ho, ts),
             {3'h0, thr, ldcmp, pwr2, pwr1, diff});
         rd(ADDR_STATUS, got);
         chk("status", exp_status(ho, rc, live, 1'b0), got);
         rd(ADDR_REF_CTRL, got);
         chk("ref_ctrl", rc, got);
         rd(ADDR_HO_CTRL, got);
         chk("ho_ctrl", ho, got);
      end
      // One enable bit alone never holds, pin or automatic
      live <= 7'h01;
      ref_ok <= 1'b1;
      sync_n <= 1'b0;
      foreach (ho[i]) begin
         if (i < 3) begin
            wr(ADDR_HO_CTRL, (i == 0) ? 8'h03 : (i == 1) ? 8'h06 : 8'h04);
            tick(3);
            chk("hold_off", 8'h00, {7'h0, hold});
         end
      end
      // External pin mode follows the pin one edge later
      wr(ADDR_HO_CTRL, 8'h07);
      tick(2);
      chk("ext_hold", 8'h01, {7'h0, hold});
      sync_n <= 1'b1;
      tick(2);
      chk("ext_release", 8'h00, {7'h0, hold});
      ref_ok <= 1'b0;
      tick(3);
      chk("ext_ignores_ref", 8'h00, {7'h0, hold});
      // Automatic mode with comparator off: pin treated as true
      ref_ok <= 1'b1;
      ld_pin <= 1'b0;
      wr(ADDR_IRQ_STAT, 8'h07);
      wr(ADDR_IRQ_MASK, 8'h01);
      wr(ADDR_HO_CTRL, 8'h05);
      rc = 8'h06;
      wr(ADDR_REF_CTRL, rc);
      tick(3);
      chk("irq_quiet", 8'h00, {7'h0, irq});
      ref_ok <= 1'b0;
      tick(3);
      chk("auto_hold", 8'h01, {7'h0, hold});
      rd(ADDR_STATUS, got);
      chk("status_hold", exp_status(8'h05, rc, live, 1'b1), got);
      tick(2);
      chk("irq_hold", 8'h01, {7'h0, irq});
      rd(ADDR_IRQ_STAT, got);
      chk("irq_stat_again", 8'h01, got & 8'h01);
      wr(ADDR_IRQ_STAT, 8'h01);
      tick(3);
      chk("irq_cleared", 8'h00, {7'h0, irq});
      ref_ok <= 1'b1;
      tick(3);
      chk("auto_recover", 8'h00, {7'h0, hold});
      // Comparator on and pin low: loss of reference does not hold
      wr(ADDR_HO_CTRL, 8'h0d);
      tick(3);
      ref_ok <= 1'b0;
      tick(3);
      chk("ld_low_nohold", 8'h00, {7'h0, hold});
      // Comparator on and pin high: relock, then a loss holds
      ld_pin <= 1'b1;
      ref_ok <= 1'b1;
      tick(3);
      ref_ok <= 1'b0;
      tick(3);
      chk("ld_high_hold", 8'h01, {7'h0, hold});
      // Calibration-done and lock-lost events, unmasked
      wr(ADDR_HO_CTRL, 8'h00);
      wr(ADDR_IRQ_STAT, 8'h07);
      wr(ADDR_IRQ_MASK, 8'h06);
      live <= 7'h40;
      tick(3);
      rd(ADDR_IRQ_STAT, got);
      chk("ev_lock_cal", 8'h06, got);
      tick(1);
      chk("irq_level", 8'h01, {7'h0, irq});
      wr(ADDR_IRQ_MASK, 8'h00);
      tick(3);
      chk("irq_masked", 8'h00, {7'h0, irq});
      // Mid-run reset drops both inputs' power and the mode again
      i_reset_n <= 1'b0;
      tick(2);
      i_reset_n <= 1'b1;
      tick(1);
      chk("ctrl_rst2", 8'h00, {3'h0, thr, ldcmp, pwr2, pwr1, diff});
      rd(ADDR_REF_CTRL, got);
      chk("ref_ctrl_rst2", REF_CTRL_RST, got);
      close_out();
   end
endmodule
